// ==== core/intc_defines.vh ====
// Constants for the interrupt priority and vectoring controller
`ifndef INTC_DEFINES_VH
`define INTC_DEFINES_VH

`define NUM_SRC          6
`define VEC_W            16
`define VEC_EXT0         16'h0003
`define VEC_TMR0         16'h000b
`define VEC_EXT1         16'h0013
`define VEC_TMR1         16'h001b
`define VEC_SERIAL       16'h0023
`define VEC_TMR2         16'h002b
`define SRC_EXT0         0
`define SRC_TMR0         1
`define SRC_EXT1         2
`define SRC_TMR1         3
`define SRC_SERIAL       4
`define SRC_TMR2         5
`define CALL_CYCLES      2

`endif

// ==== core/ext_request_capture.v ====
// External request pin sampling and request flag logic
`timescale 1ns/1ps
`include "intc_defines.vh"

module ext_request_capture (
  input  wire i_sys_clk,
  input  wire i_resetn,
  input  wire i_sample_phase,
  input  wire i_ext_request_pin,
  input  wire i_trigger_type,
  input  wire i_ack_clear,
  output wire o_flag
);

  reg pin_sample_q;
  reg flag_q;

  assign o_flag = flag_q;

  // Sampled pin starts high so a low at release is taken as an edge
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_sample_q <= 1'b1;
      flag_q       <= 1'b0;
    end else begin
      if (i_sample_phase) begin
        pin_sample_q <= i_ext_request_pin;
        if (!i_trigger_type) begin
          flag_q <= ~i_ext_request_pin;
        end else if (pin_sample_q && !i_ext_request_pin) begin
          flag_q <= 1'b1;
        end else if (i_ack_clear) begin
          flag_q <= 1'b0;
        end
      end else if (i_ack_clear && i_trigger_type) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule // ext_request_capture

// ==== core/in_progress_tracker.v ====
// In-progress tracking for the two priority levels
`timescale 1ns/1ps
`include "intc_defines.vh"

module in_progress_tracker (
  input  wire i_sys_clk,
  input  wire i_resetn,
  input  wire i_set_valid,
  input  wire i_set_level,
  input  wire i_handler_exit,
  output wire o_low_busy,
  output wire o_high_busy
);

  reg low_q;
  reg high_q;

  assign o_low_busy  = low_q;
  assign o_high_busy = high_q;

  // Exit clears the highest level active: the running handler is always the top one
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_q  <= 1'b0;
      high_q <= 1'b0;
    end else begin
      if (i_handler_exit) begin
        if (high_q) begin
          high_q <= 1'b0;
        end else begin
          low_q <= 1'b0;
        end
      end
      if (i_set_valid) begin
        if (i_set_level) begin
          high_q <= 1'b1;
        end else begin
          low_q <= 1'b1;
        end
      end
    end
  end

endmodule // in_progress_tracker

// ==== core/interrupt_priority_vectoring.v ====
// Interrupt priority resolution and hardware call vectoring
//
// Operation
// - Same-level ties resolve ext0, timer0, ext1, timer1, serial, timer2.
// - Polling order only breaks ties, never preempts a running handler.
// - Sample flags at sample phase, evaluate them the next machine cycle.
// - No call while an equal or higher level handler is running.
// - No call unless poll cycle is the instruction's last cycle.
// - No call during handler exit or enable/level register access.
// - Blocked requests are not remembered; each poll uses fresh samples.
// - Serial and timer2 flags are never cleared on acknowledge.
// - External flag cleared on acknowledge only in edge mode.
// - Call pushes program counter only, status word not saved.
// - Call loads vector 0003,000b,0013,001b,0023,002b by source.
// - Handler exit clears current level busy state and pops two bytes.
// - Subroutine exit leaves the busy state untouched.
// - Trigger type 0 makes low level request; 1 makes edge request.
// - Edge mode sets flag on high sample followed by low sample.
// - In level mode, pin levels inverted and latched into flags at sample phase.
// - Hardware call spans two machine cycles.
// - Single source latency is above 3 and below 8 machine cycles.
// - Higher request sampled during lower call start is vectored next.
// - Different-level simultaneous requests: higher level served first.
`timescale 1ns/1ps
`include "intc_defines.vh"

module interrupt_priority_vectoring (
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire        i_sample_phase,
  input  wire        i_last_cycle,
  input  wire        i_handler_exit_op,
  input  wire        i_subroutine_exit_op,
  input  wire        i_mask_or_level_access,
  input  wire        i_ext_request_pin0,
  input  wire        i_ext_request_pin1,
  input  wire        i_ext0_trigger_type,
  input  wire        i_ext1_trigger_type,
  input  wire        i_timer0_overflow_flag,
  input  wire        i_timer1_overflow_flag,
  input  wire        i_receive_done_flag,
  input  wire        i_transmit_done_flag,
  input  wire        i_timer2_overflow_flag,
  input  wire        i_timer2_external_flag,
  input  wire        i_global_enable,
  input  wire [5:0]  i_source_enable,
  input  wire [5:0]  i_source_level,
  output reg         o_call_req,
  output reg         o_call_active,
  output reg  [15:0] o_call_vector,
  output reg         o_push_pc,
  output reg         o_pop_pc,
  output reg         o_ext0_flag,
  output reg         o_ext1_flag,
  output reg         o_low_in_progress,
  output reg         o_high_in_progress
);

  // --------------------------------------------------------------------------
  // Call sequencer states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_CALL1 = 3'b010;
  localparam [2:0] ST_CALL2 = 3'b100;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  wire       ext0_flag;
  wire       ext1_flag;
  wire       low_busy;
  wire       high_busy;
  reg  [5:0] sample_q;
  reg  [5:0] raw_d;
  reg  [5:0] req_d;
  reg  [5:0] poll_d;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [2:0] pick_d;
  reg        pick_hi_d;
  reg        found_d;
  reg        grant_d;
  reg  [2:0] grant_src_q;
  reg        grant_level_q;
  reg        ack_ext0_d;
  reg        ack_ext1_d;
  reg        set_valid_d;
  reg [15:0] vec_d;
  integer    k;

  // --------------------------------------------------------------------------
  // External request flags
  // --------------------------------------------------------------------------
  ext_request_capture u_ext0 (
    .i_sys_clk         (i_sys_clk),
    .i_resetn          (i_resetn),
    .i_sample_phase    (i_sample_phase),
    .i_ext_request_pin (i_ext_request_pin0),
    .i_trigger_type    (i_ext0_trigger_type),
    .i_ack_clear       (ack_ext0_d),
    .o_flag            (ext0_flag)
  );

  ext_request_capture u_ext1 (
    .i_sys_clk         (i_sys_clk),
    .i_resetn          (i_resetn),
    .i_sample_phase    (i_sample_phase),
    .i_ext_request_pin (i_ext_request_pin1),
    .i_trigger_type    (i_ext1_trigger_type),
    .i_ack_clear       (ack_ext1_d),
    .o_flag            (ext1_flag)
  );

  // --------------------------------------------------------------------------
  // Flag sampling
  // --------------------------------------------------------------------------
  // Serial and timer2 pairs share one vector each; their flags stay owned
  // by the peripherals and are only read here
  always @* begin
    raw_d[`SRC_EXT0]   = ext0_flag;
    raw_d[`SRC_TMR0]   = i_timer0_overflow_flag;
    raw_d[`SRC_EXT1]   = ext1_flag;
    raw_d[`SRC_TMR1]   = i_timer1_overflow_flag;
    raw_d[`SRC_SERIAL] = i_receive_done_flag | i_transmit_done_flag;
    raw_d[`SRC_TMR2]   = i_timer2_overflow_flag | i_timer2_external_flag;
  end

  always @* begin
    req_d = raw_d & i_source_enable & {6{i_global_enable}};
  end

  // Samples are overwritten every machine cycle, so nothing pending survives
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sample_q <= 6'h00;
    end else if (i_sample_phase) begin
      sample_q <= req_d;
    end
  end

  // External flags are already latched at sample phase; sampling them a
  // second time would add a machine cycle to their response time
  always @* begin
    poll_d            = sample_q;
    poll_d[`SRC_EXT0] = req_d[`SRC_EXT0];
    poll_d[`SRC_EXT1] = req_d[`SRC_EXT1];
  end

  // --------------------------------------------------------------------------
  // Priority resolution
  // --------------------------------------------------------------------------
  // Scan from highest to lowest order so the earliest source wins a tie
  always @* begin
    pick_d    = 3'd0;
    pick_hi_d = 1'b0;
    found_d   = 1'b0;
    for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
      if (poll_d[k] && i_source_level[k]) begin
        pick_d    = k[2:0];
        pick_hi_d = 1'b1;
        found_d   = 1'b1;
      end
    end
    if (!found_d) begin
      for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
        if (poll_d[k]) begin
          pick_d  = k[2:0];
          found_d = 1'b1;
        end
      end
    end
  end

  // Level gating only: order never outranks a running handler
  always @* begin
    grant_d = found_d && i_sample_phase &&
              ((state_q == ST_IDLE) || (state_q == ST_CALL2));
    if (high_busy || (low_busy && !pick_hi_d)) begin
      grant_d = 1'b0;
    end
    if (!i_last_cycle) begin
      grant_d = 1'b0;
    end
    if (i_handler_exit_op || i_mask_or_level_access) begin
      grant_d = 1'b0;
    end
  end

  // Only the edge-mode external flags are cleared by acknowledge
  always @* begin
    ack_ext0_d = grant_d && (pick_d == `SRC_EXT0);
    ack_ext1_d = grant_d && (pick_d == `SRC_EXT1);
    set_valid_d = grant_d;
  end

  in_progress_tracker u_busy (
    .i_sys_clk      (i_sys_clk),
    .i_resetn       (i_resetn),
    .i_set_valid    (set_valid_d),
    .i_set_level    (pick_hi_d),
    .i_handler_exit (i_handler_exit_op),
    .o_low_busy     (low_busy),
    .o_high_busy    (high_busy)
  );

  // --------------------------------------------------------------------------
  // Vector lookup
  // --------------------------------------------------------------------------
  always @* begin
    case (grant_src_q)
      3'd0:    vec_d = `VEC_EXT0;
      3'd1:    vec_d = `VEC_TMR0;
      3'd2:    vec_d = `VEC_EXT1;
      3'd3:    vec_d = `VEC_TMR1;
      3'd4:    vec_d = `VEC_SERIAL;
      3'd5:    vec_d = `VEC_TMR2;
      default: vec_d = `VEC_EXT0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Call sequencer
  // --------------------------------------------------------------------------
  // Two machine cycles, each closed by a sample phase; a higher request
  // sampled in the first call cycle is granted at the edge ending the call,
  // so no handler instruction of the lower level runs first
  always @* begin
    case (state_q)
      ST_IDLE:  state_d = grant_d ? ST_CALL1 : ST_IDLE;
      ST_CALL1: state_d = i_sample_phase ? ST_CALL2 : ST_CALL1;
      ST_CALL2: state_d = !i_sample_phase ? ST_CALL2 :
                          (grant_d ? ST_CALL1 : ST_IDLE);
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q       <= ST_IDLE;
      grant_src_q   <= 3'd0;
      grant_level_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (grant_d) begin
        grant_src_q   <= pick_d;
        grant_level_q <= pick_hi_d;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  // Push is the program counter only; status word is left to software
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_call_req         <= 1'b0;
      o_call_active      <= 1'b0;
      o_call_vector      <= 16'h0000;
      o_push_pc          <= 1'b0;
      o_pop_pc           <= 1'b0;
      o_ext0_flag        <= 1'b0;
      o_ext1_flag        <= 1'b0;
      o_low_in_progress  <= 1'b0;
      o_high_in_progress <= 1'b0;
    end else begin
      o_call_req         <= grant_d;
      o_call_active      <= (state_q != ST_IDLE);
      o_call_vector      <= vec_d;
      o_push_pc          <= (state_q == ST_CALL1) && i_sample_phase;
      o_pop_pc           <= i_handler_exit_op;
      o_ext0_flag        <= ext0_flag;
      o_ext1_flag        <= ext1_flag;
      o_low_in_progress  <= low_busy;
      o_high_in_progress <= high_busy;
    end
  end

endmodule // interrupt_priority_vectoring

// ==== test/intc_checker.sv ====
// Port checker for the interrupt vectoring controller
`timescale 1ns/1ps
module intc_checker (
  input wire        i_sys_clk,
  input wire        i_resetn,
  input wire        i_sample_phase,
  input wire        i_last_cycle,
  input wire        i_handler_exit_op,
  input wire        i_mask_or_level_access,
  input wire        o_call_req,
  input wire        o_call_active,
  input wire [15:0] o_call_vector,
  input wire        o_push_pc,
  input wire        o_pop_pc,
  input wire        o_low_in_progress,
  input wire        o_high_in_progress
);
  // ----------------------------------------
  // Grant, call and return relations
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  sample_grant_a: assert property (o_call_req |-> $past(i_sample_phase))
    else $error("call off sample phase");
  clear_grant_a: assert property (o_call_req |-> $past(i_last_cycle) &&
    !$past(i_mask_or_level_access) && !$past(i_handler_exit_op))
    else $error("call while blocked");
  vector_legal_a: assert property (o_call_req |=> o_call_vector inside {16'h0003,
    16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b})
    else $error("bad vector");
  busy_set_a: assert property (o_call_req |=> o_low_in_progress || o_high_in_progress)
    else $error("no busy after call");
  high_block_a: assert property (o_call_req |-> !o_high_in_progress)
    else $error("call over high handler");
  push_follow_a: assert property (o_call_req |-> ##[1:8] o_push_pc)
    else $error("no push after call");
  pop_follow_a: assert property (i_handler_exit_op |=> o_pop_pc)
    else $error("no pop after exit");
  pop_cause_a: assert property (o_pop_pc |-> $past(i_handler_exit_op))
    else $error("pop without exit");
  active_follow_a: assert property (o_call_req |=> o_call_active)
    else $error("call not active");
endmodule // intc_checker

// ==== test/cpu_sequencer_model.sv ====
// Machine-cycle sequencer stand-in driving sample phase and last cycle
`timescale 1ns/1ps
module cpu_sequencer_model #(
  parameter MC_CLKS = 6
) (
  input  wire i_sys_clk,
  input  wire i_resetn,
  input  wire i_long_instr,
  output reg  o_sample_phase,
  output reg  o_last_cycle
);
  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  reg [3:0] cnt_q;
  // Falling edge keeps the outputs settled at the sampling edge
  always @(negedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 4'h0;
      o_sample_phase <= 1'b0;
      o_last_cycle <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == MC_CLKS - 1) ? 4'h0 : cnt_q + 4'h1;
      o_sample_phase <= (cnt_q == MC_CLKS - 1);
      o_last_cycle <= !i_long_instr;
    end
  end
endmodule // cpu_sequencer_model

// ==== test/interrupt_priority_vectoring_tb.sv ====
// Self-checking bench for the interrupt vectoring controller
`timescale 1ns/1ps
`include "intc_defines.vh"
module interrupt_priority_vectoring_tb;
  logic        clk, rstn, sp, lc, hx, sx, ma, p0, p1, t0m, t1m;
  logic        tf0, tf1, rx, tx, tf2, ex2, ge, long_i;
  logic [5:0]  en, lvl;
  wire         cr, pop, f0, f1, lip, act;
  wire  [15:0] vec;
  int          err_count, samples_checked, cyc;
  logic [15:0] vtab [6] = '{`VEC_EXT0, `VEC_TMR0, `VEC_EXT1, `VEC_TMR1, `VEC_SERIAL, `VEC_TMR2};

  cpu_sequencer_model #(.MC_CLKS(6)) seq_u (.i_sys_clk(clk), .i_resetn(rstn),
    .i_long_instr(long_i), .o_sample_phase(sp), .o_last_cycle(lc));
  interrupt_priority_vectoring dut_u (
    .i_sys_clk(clk), .i_resetn(rstn), .i_sample_phase(sp), .i_last_cycle(lc),
    .i_handler_exit_op(hx), .i_subroutine_exit_op(sx), .i_mask_or_level_access(ma),
    .i_ext_request_pin0(p0), .i_ext_request_pin1(p1), .i_ext0_trigger_type(t0m),
    .i_ext1_trigger_type(t1m), .i_timer0_overflow_flag(tf0), .i_timer1_overflow_flag(tf1),
    .i_receive_done_flag(rx), .i_transmit_done_flag(tx), .i_timer2_overflow_flag(tf2),
    .i_timer2_external_flag(ex2), .i_global_enable(ge), .i_source_enable(en),
    .i_source_level(lvl), .o_call_req(cr), .o_call_active(act), .o_call_vector(vec),
    .o_push_pc(), .o_pop_pc(pop), .o_ext0_flag(f0), .o_ext1_flag(f1),
    .o_low_in_progress(lip), .o_high_in_progress());

  always #2 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // External pins are active low
  task automatic src(input logic [5:0] m);
    p0 = !m[0];
    tf0 = m[1];
    p1 = !m[2];
    tf1 = m[3];
    rx = m[4];
    ex2 = m[5];
  endtask
  // Window spans sample, grant and the whole two-cycle call
  task automatic want(input logic w, input logic [15:0] v, input string m);
    logic got;
    got = 1'b0;
    repeat (30) begin
      @(negedge clk);
      if (cr === 1'b1) got = 1'b1;
    end
    chk(got === w, m);
    if (w) chk(vec === v, m);
  endtask
  // Level sources must be gone two machine cycles before the handler ends
  task automatic exit_h;
    clks(14);
    hx = 1'b1;
    clks(1);
    hx = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_order;
    for (int k = 0; k < 6; k++) begin
      src(6'h3f << k);
      want(1'b1, vtab[k], "tie order");
      if (k == 0) chk(f0 === 1'b1, "level flag lost");
      src(6'h00);
      exit_h;
    end
    tx = 1'b1;
    want(1'b1, `VEC_SERIAL, "tx pair");
    tx = 1'b0;
    exit_h;
    tf2 = 1'b1;
    want(1'b1, `VEC_TMR2, "ovf pair");
    tf2 = 1'b0;
    exit_h;
    $display("t_order done");
  endtask
  task automatic t_level;
    lvl = 6'h08;
    src(6'h0a);
    want(1'b1, `VEC_TMR1, "level order");
    src(6'h02);
    want(1'b0, 16'h0000, "low over high");
    exit_h;
    want(1'b1, `VEC_TMR0, "low lost");
    src(6'h03);
    want(1'b0, 16'h0000, "same level preempt");
    src(6'h01);
    exit_h;
    want(1'b1, `VEC_EXT0, "ext0 lost");
    src(6'h00);
    exit_h;
    lvl = 6'h00;
    $display("t_level done");
  endtask
  task automatic t_block;
    long_i = 1'b1;
    src(6'h08);
    want(1'b0, 16'h0000, "mid instr call");
    src(6'h00);
    clks(12);
    long_i = 1'b0;
    want(1'b0, 16'h0000, "stale request");
    ma = 1'b1;
    tf0 = 1'b1;
    want(1'b0, 16'h0000, "call on access");
    ma = 1'b0;
    want(1'b1, `VEC_TMR0, "lost after access");
    tf0 = 1'b0;
    exit_h;
    en = 6'h3d;
    tf0 = 1'b1;
    want(1'b0, 16'h0000, "disabled source");
    en = 6'h3f;
    ge = 1'b0;
    want(1'b0, 16'h0000, "global off");
    ge = 1'b1;
    want(1'b1, `VEC_TMR0, "enable lost");
    tf0 = 1'b0;
    exit_h;
    $display("t_block done");
  endtask
  task automatic t_edge;
    t1m = 1'b1;
    clks(12);
    p1 = 1'b0;
    want(1'b1, `VEC_EXT1, "edge request");
    chk(f1 === 1'b0, "edge flag kept");
    sx = 1'b1;
    clks(1);
    sx = 1'b0;
    clks(2);
    chk(lip === 1'b1, "busy lost on return");
    exit_h;
    chk(pop === 1'b1, "no pop");
    clks(2);
    chk(lip === 1'b0, "busy kept");
    t0m = 1'b1;
    clks(12);
    p0 = 1'b0;
    want(1'b1, `VEC_EXT0, "edge0 request");
    chk(f0 === 1'b0, "edge0 flag kept");
    p0 = 1'b1;
    exit_h;
    t0m = 1'b0;
    p1 = 1'b1;
    t1m = 1'b0;
    $display("t_edge done");
  endtask

  // Higher request raised in the first call cycle must follow at the call's end
  task automatic t_nest;
    int n;
    lvl = 6'h08;
    tf0 = 1'b1;
    n = 0;
    while (cr !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    tf1 = 1'b1;
    n = 1;
    @(negedge clk);
    while (cr !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n == 2 * 6, "high not next");
    clks(2);
    chk(vec === `VEC_TMR1, "nest vector");
    tf0 = 1'b0;
    tf1 = 1'b0;
    exit_h;
    exit_h;
    lvl = 6'h00;
    $display("t_nest done");
  endtask
  // Request to end of call, in clocks of a six-clock machine cycle
  task automatic t_latency;
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    tf0 = 1'b1;
    while (n < 60 && !(seen && act === 1'b0)) begin
      @(negedge clk);
      n++;
      if (act === 1'b1) seen = 1'b1;
    end
    chk(seen && n > 3 * 6 && n < 8 * 6, "response time");
    tf0 = 1'b0;
    exit_h;
    $display("t_latency done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {hx, sx, ma, t0m, t1m, tx, tf2, long_i} = '0;
    src(6'h00);
    ge = 1'b1;
    en = 6'h3f;
    lvl = 6'h00;
    clks(20);
    rstn = 1'b1;
    clks(2);
    t_order;
    t_level;
    t_block;
    t_edge;
    t_nest;
    t_latency;
    tally_and_finish;
  end

  // Hang guard well above the roughly 1000 cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish;
    end
  end
endmodule // interrupt_priority_vectoring_tb

bind interrupt_priority_vectoring intc_checker chk_u (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_sample_phase(i_sample_phase), .i_last_cycle(i_last_cycle),
  .i_handler_exit_op(i_handler_exit_op), .i_mask_or_level_access(i_mask_or_level_access),
  .o_call_req(o_call_req), .o_call_active(o_call_active),
  .o_call_vector(o_call_vector), .o_push_pc(o_push_pc),
  .o_pop_pc(o_pop_pc), .o_low_in_progress(o_low_in_progress),
  .o_high_in_progress(o_high_in_progress));
